/* rtl/pcb_defs.svh */
// constants for the pin port and clock block logic
`ifndef PCB_DEFS_SVH
`define PCB_DEFS_SVH

`define PCB_NPORT     5
`define PCB_NCB       6
`define PCB_NPIN      32
`define PCB_W0        1
`define PCB_W1        4
`define PCB_W2        8
`define PCB_W3        16
`define PCB_W4        32
`define PCB_WORD      32

`define PCB_PORT_END  8'h50
`define PCB_CB_BASE   8'h80
`define PCB_CB_END    8'h98
`define PCB_GLB_BASE  8'hA0
`define PCB_GLB_END   8'hB0

`define PCB_SUB_CTRL  2'h0
`define PCB_SUB_DATA  2'h1
`define PCB_SUB_TIME  2'h2
`define PCB_SUB_STAMP 2'h3

`define PCB_GLB_CTRL  2'h0
`define PCB_GLB_STAT  2'h1
`define PCB_GLB_MASK  2'h2
`define PCB_GLB_PINS  2'h3

`define PCB_LINK_PINS 32'h0000FF00
`define PCB_CTRL_RST  32'h00000000
`define PCB_CB_RST    32'h00000000
`define PCB_MASK_RST  5'h00
`define PCB_CB_REF    3'h0

`endif

/* rtl/pcb_pkg.sv */
// types for the pin port and clock block logic
package pcb_pkg;

  typedef enum logic [1:0] {
    PCB_COND_NONE = 2'h0,
    PCB_COND_EQ   = 2'h1,
    PCB_COND_NEQ  = 2'h2
  } pcb_cond_e;

  typedef struct packed {
    logic [15:0] cond_val;
    logic [5:0]  rsvd;
    logic        strobe_out_en;
    logic        strobe_in_en;
    pcb_cond_e   cond;
    logic [2:0]  clk_sel;
    logic        open_drain;
    logic        dir_out;
    logic        enable;
  } pcb_pcfg_s;

  typedef struct packed {
    logic [15:0] rsvd_hi;
    logic [7:0]  div;
    logic [6:0]  rsvd_lo;
    logic        src_pin;
  } pcb_cbcfg_s;

  typedef enum logic {
    PCB_PST_IDLE  = 1'b0,
    PCB_PST_SHIFT = 1'b1
  } pcb_pst_e;

  typedef enum logic [1:0] {
    PCB_RG_NONE = 2'h0,
    PCB_RG_PORT = 2'h1,
    PCB_RG_CB   = 2'h3,
    PCB_RG_GLB  = 2'h2
  } pcb_rg_e;

  typedef struct packed {
    pcb_rg_e    rg;
    logic [2:0] idx;
    logic [1:0] sub;
  } pcb_dec_s;

endpackage : pcb_pkg

/* rtl/pcb_port.sv */
// one port: serializer, transfer register, counter and timestamp
`timescale 1ns/1ps
`include "pcb_defs.svh"
module pcb_port #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // timing and strobe
  input  wire logic              tick,
  input  wire logic              rdy_in,
  // configuration and pins
  input  wire pcb_pkg::pcb_pcfg_s cfg,
  input  wire logic [31:0]       pins_i,
  output logic      [31:0]       pins_o,
  output logic                   strobe_o,
  // processor side
  input  wire logic              wr_data,
  input  wire logic              wr_time,
  input  wire logic              rd_data,
  input  wire logic [31:0]       wdata,
  output logic      [31:0]       xfer_o,
  output logic                   full_o,
  output logic      [15:0]       count_o,
  output logic      [15:0]       stamp_o,
  output logic                   event_o
);
  localparam int         NSL  = `PCB_WORD / WIDTH;
  localparam logic [4:0] LAST = 5'(NSL - 1);
  localparam logic [31:0] MASK = 32'((64'h1 << WIDTH) - 64'h1);

  pcb_pkg::pcb_pst_e st_q;
  logic [31:0] shift_q, xfer_q, out_q;
  logic [4:0]  slot_q;
  logic [15:0] cnt_q, time_q, stamp_q;
  logic        armed_q, full_q, stb_q, ev_q;
  logic        time_ok, strobe_ok, cond_ok, go, in_go, in_word, out_load, busy_tick;
  logic [31:0] in_next;

  // new samples enter at the top so the first slice ends in the low bits
  function automatic logic [31:0] slice_in(input logic [31:0] sh, input logic [31:0] p);
    slice_in = (sh >> WIDTH) | ((p & MASK) << (`PCB_WORD - WIDTH));
  endfunction : slice_in

  always_comb begin
    unique case (cfg.cond)
      pcb_pkg::PCB_COND_NONE: cond_ok = 1'b1;
      pcb_pkg::PCB_COND_EQ:   cond_ok = (pins_i[15:0] == cfg.cond_val);
      pcb_pkg::PCB_COND_NEQ:  cond_ok = (pins_i[15:0] != cfg.cond_val);
      default:                cond_ok = 1'b0;
    endcase
  end

  assign time_ok   = ~armed_q | (cnt_q == time_q);
  assign strobe_ok = ~cfg.strobe_in_en | rdy_in;
  assign go        = tick & cfg.enable & time_ok;
  assign in_go     = go & ~cfg.dir_out & strobe_ok & cond_ok;
  assign in_word   = in_go & (slot_q == LAST);
  assign out_load  = go & cfg.dir_out & full_q & (st_q == pcb_pkg::PCB_PST_IDLE);
  assign busy_tick = tick & cfg.enable & cfg.dir_out & (st_q == pcb_pkg::PCB_PST_SHIFT);
  assign in_next   = slice_in(shift_q, pins_i);

  // counter advances per selected clock edge and wraps
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (tick && cfg.enable) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      time_q  <= 16'h0000;
      armed_q <= 1'b0;
    end else if (wr_time) begin
      time_q  <= wdata[15:0];
      armed_q <= 1'b1;
    end else if (in_word || out_load) begin
      armed_q <= 1'b0;
    end
  end

  // serializer, shared by both directions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= pcb_pkg::PCB_PST_IDLE;
      shift_q <= 32'h00000000;
      out_q   <= 32'h00000000;
      slot_q  <= 5'h00;
    end else if (in_go) begin
      shift_q <= in_next;
      slot_q  <= in_word ? 5'h00 : slot_q + 5'h01;
    end else if (out_load) begin
      out_q   <= xfer_q & MASK;
      shift_q <= xfer_q >> WIDTH;
      slot_q  <= (LAST == 5'h00) ? 5'h00 : 5'h01;
      st_q    <= (NSL > 1) ? pcb_pkg::PCB_PST_SHIFT : pcb_pkg::PCB_PST_IDLE;
    end else if (busy_tick) begin
      out_q   <= shift_q & MASK;
      shift_q <= shift_q >> WIDTH;
      slot_q  <= (slot_q == LAST) ? 5'h00 : slot_q + 5'h01;
      st_q    <= (slot_q == LAST) ? pcb_pkg::PCB_PST_IDLE : pcb_pkg::PCB_PST_SHIFT;
    end
  end

  // transfer register; a new word wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_q <= 32'h00000000;
      full_q <= 1'b0;
    end else begin
      if (wr_data) begin
        xfer_q <= wdata;
      end else if (in_word) begin
        xfer_q <= in_next;
      end
      if (wr_data || in_word) begin
        full_q <= 1'b1;
      end else if (rd_data || out_load) begin
        full_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stamp_q <= 16'h0000;
      ev_q    <= 1'b0;
      stb_q   <= 1'b0;
    end else begin
      if (in_word || out_load) begin
        stamp_q <= cnt_q;
      end
      ev_q <= in_word | out_load;
      if (tick) begin
        stb_q <= cfg.strobe_out_en & (out_load | busy_tick);
      end
    end
  end

  assign pins_o   = out_q;
  assign strobe_o = stb_q;
  assign xfer_o   = xfer_q;
  assign full_o   = full_q;
  assign count_o  = cnt_q;
  assign stamp_o  = stamp_q;
  assign event_o  = ev_q;

endmodule : pcb_port

/* rtl/pcb_top.sv */
// pin ports, clock blocks and pin sharing behind an apb register slave
//
// Summary of operation
// - five ports of 1, 4, 8, 16 and 32 bits, each on fixed pins.
// - all pins of a port share one direction, input or output.
// - ports drive pins high or low, or sample them, optionally on a condition.
// - open-drain mode per port: drive low for zero, release for one.
// - data passes through a per-port serializer and transfer register.
// - a 16-bit port counter is readable and can delay a transfer.
// - every transfer captures the counter as a readable timestamp.
// - an enabled link takes its shared pins away from the ports.
// - a narrower enabled port overrides wider ones on shared pins only.
// - a port always transfers at its own nominal width.
// - six clock blocks; block 0 is the 100 MHz reference.
// - a clock block may take its clock from the 1-bit port pin.
// - a pin-sourced clock block may divide that clock.
// - ports accept ready-in strobes and can emit strobe_out with data.
// - after reset every port runs from clock block 0.
// - every register access by the processor completes without wait cycles.
// - port events reach the scheduler side directly.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "pcb_defs.svh"
module pcb_top (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // pins
  input  wire logic [31:0] PIN_I,
  output logic      [31:0] PIN_O,
  output logic      [31:0] PIN_OE,
  // strobes
  input  wire logic [4:0]  RDY_IN,
  output logic      [4:0]  STROBE_OUT,
  // events
  output logic      [4:0]  PORT_EVENT,
  output logic             IRQ
);

  function automatic int port_width(input int p);
    case (p)
      0:       port_width = `PCB_W0;
      1:       port_width = `PCB_W1;
      2:       port_width = `PCB_W2;
      3:       port_width = `PCB_W3;
      default: port_width = `PCB_W4;
    endcase
  endfunction : port_width

  function automatic pcb_pkg::pcb_dec_s decode(input logic [7:0] a);
    pcb_pkg::pcb_dec_s d;
    d.rg  = pcb_pkg::PCB_RG_NONE;
    d.idx = 3'h0;
    d.sub = a[3:2];
    if (a[1:0] != 2'h0) begin
      d.rg = pcb_pkg::PCB_RG_NONE;
    end else if (a < `PCB_PORT_END) begin
      d.rg  = pcb_pkg::PCB_RG_PORT;
      d.idx = a[6:4];
    end else if (a >= `PCB_CB_BASE && a < `PCB_CB_END) begin
      d.rg  = pcb_pkg::PCB_RG_CB;
      d.idx = a[4:2];
    end else if (a >= `PCB_GLB_BASE && a < `PCB_GLB_END) begin
      d.rg = pcb_pkg::PCB_RG_GLB;
    end
    decode = d;
  endfunction : decode

  pcb_pkg::pcb_dec_s   dec;
  pcb_pkg::pcb_pcfg_s  pcfg_q [`PCB_NPORT];
  pcb_pkg::pcb_cbcfg_s cbcfg_q [`PCB_NCB];

  logic        pready_q, pslverr_q, acc, acc_wr, acc_rd, link_en_q, irq_q, pin0_d_q;
  logic [31:0] prdata_q, rd_d, pin_s1_q, pin_s2_q, pin_o_q, pin_oe_q, po_d, poe_d;
  logic [4:0]  rdy_s1_q, rdy_s2_q, stat_q, mask_q, evt_q, stb_q, stat_clr;
  logic [4:0]  wr_data, wr_time, rd_data, tick_w, full_w, stb_w, ev_w;
  logic [5:0]  cb_tick_q;
  logic [7:0]  cb_cnt_q [`PCB_NCB];
  logic [31:0] pout_w [`PCB_NPORT];
  logic [31:0] xfer_w [`PCB_NPORT];
  logic [15:0] cnt_w [`PCB_NPORT];
  logic [15:0] stamp_w [`PCB_NPORT];
  logic        pin0_rise;

  localparam logic [31:0] LINK_PINS = `PCB_LINK_PINS;

  assign dec    = decode(PADDR);
  assign acc    = PSEL & PENABLE & pready_q;
  assign acc_wr = acc & PWRITE;
  assign acc_rd = acc & ~PWRITE;

  // pin and strobe synchronisers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pin_s1_q <= 32'h00000000;
      pin_s2_q <= 32'h00000000;
      rdy_s1_q <= 5'h00;
      rdy_s2_q <= 5'h00;
      pin0_d_q <= 1'b0;
    end else begin
      pin_s1_q <= PIN_I;
      pin_s2_q <= pin_s1_q;
      rdy_s1_q <= RDY_IN;
      rdy_s2_q <= rdy_s1_q;
      pin0_d_q <= pin_s2_q[0];
    end
  end

  assign pin0_rise = pin_s2_q[0] & ~pin0_d_q;

  // apb: one access cycle, never stretched
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q <= PSEL & ~PENABLE;
      if (PSEL && !PENABLE) begin
        prdata_q  <= PWRITE ? 32'h00000000 : rd_d;
        pslverr_q <= (dec.rg == pcb_pkg::PCB_RG_NONE);
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_d = 32'h00000000;
    unique case (dec.rg)
      pcb_pkg::PCB_RG_PORT: begin
        unique case (dec.sub)
          `PCB_SUB_CTRL:  rd_d = pcfg_q[dec.idx];
          `PCB_SUB_DATA:  rd_d = xfer_w[dec.idx];
          `PCB_SUB_TIME:  rd_d = {15'h0000, full_w[dec.idx], cnt_w[dec.idx]};
          `PCB_SUB_STAMP: rd_d = {16'h0000, stamp_w[dec.idx]};
        endcase
      end
      pcb_pkg::PCB_RG_CB: rd_d = (dec.idx == `PCB_CB_REF) ? 32'h00000000 : cbcfg_q[dec.idx];
      pcb_pkg::PCB_RG_GLB: begin
        unique case (dec.sub)
          `PCB_GLB_CTRL: rd_d = {31'h00000000, link_en_q};
          `PCB_GLB_STAT: rd_d = {27'h0000000, stat_q};
          `PCB_GLB_MASK: rd_d = {27'h0000000, mask_q};
          `PCB_GLB_PINS: rd_d = pin_s2_q;
        endcase
      end
      pcb_pkg::PCB_RG_NONE: rd_d = 32'h00000000;
    endcase
  end

  // per-port strobes from the access phase, and each port's tick from its selected clock block
  always_comb begin
    for (int p = 0; p < `PCB_NPORT; p++) begin
      wr_data[p] = acc_wr && dec.rg == pcb_pkg::PCB_RG_PORT && dec.idx == 3'(p)
                   && dec.sub == `PCB_SUB_DATA;
      wr_time[p] = acc_wr && dec.rg == pcb_pkg::PCB_RG_PORT && dec.idx == 3'(p)
                   && dec.sub == `PCB_SUB_TIME;
      rd_data[p] = acc_rd && dec.rg == pcb_pkg::PCB_RG_PORT && dec.idx == 3'(p)
                   && dec.sub == `PCB_SUB_DATA;
      tick_w[p]  = (pcfg_q[p].clk_sel < 3'(`PCB_NCB)) ? cb_tick_q[pcfg_q[p].clk_sel] : 1'b0;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < `PCB_NPORT; p++) begin
        pcfg_q[p] <= pcb_pkg::pcb_pcfg_s'(`PCB_CTRL_RST);
      end
    end else if (acc_wr && dec.rg == pcb_pkg::PCB_RG_PORT && dec.sub == `PCB_SUB_CTRL) begin
      pcfg_q[dec.idx] <= pcb_pkg::pcb_pcfg_s'(PWDATA);
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < `PCB_NCB; i++) begin
        cbcfg_q[i] <= pcb_pkg::pcb_cbcfg_s'(`PCB_CB_RST);
      end
    end else if (acc_wr && dec.rg == pcb_pkg::PCB_RG_CB && dec.idx != `PCB_CB_REF) begin
      cbcfg_q[dec.idx] <= pcb_pkg::pcb_cbcfg_s'(PWDATA);
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      link_en_q <= 1'b0;
      mask_q    <= `PCB_MASK_RST;
    end else if (acc_wr && dec.rg == pcb_pkg::PCB_RG_GLB) begin
      if (dec.sub == `PCB_GLB_CTRL) begin
        link_en_q <= PWDATA[0];
      end
      if (dec.sub == `PCB_GLB_MASK) begin
        mask_q <= PWDATA[4:0];
      end
    end
  end

  // clock blocks; block 0 ticks on every reference edge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cb_tick_q <= 6'h00;
      for (int i = 0; i < `PCB_NCB; i++) begin
        cb_cnt_q[i] <= 8'h00;
      end
    end else begin
      cb_tick_q[0] <= 1'b1;
      for (int i = 1; i < `PCB_NCB; i++) begin
        if (!cbcfg_q[i].src_pin || pin0_rise) begin
          if (cb_cnt_q[i] >= cbcfg_q[i].div) begin
            cb_tick_q[i] <= 1'b1;
            cb_cnt_q[i]  <= 8'h00;
          end else begin
            cb_tick_q[i] <= 1'b0;
            cb_cnt_q[i]  <= cb_cnt_q[i] + 8'h01;
          end
        end else begin
          cb_tick_q[i] <= 1'b0;
        end
      end
    end
  end

  for (genvar p = 0; p < `PCB_NPORT; p++) begin : g_port
    pcb_port #(
      .WIDTH (port_width(p))
    ) u_port (
      .clk      (MCLK),
      .rst      (RST),
      .tick     (tick_w[p]),
      .rdy_in   (rdy_s2_q[p]),
      .cfg      (pcfg_q[p]),
      .pins_i   (pin_s2_q),
      .pins_o   (pout_w[p]),
      .strobe_o (stb_w[p]),
      .wr_data  (wr_data[p]),
      .wr_time  (wr_time[p]),
      .rd_data  (rd_data[p]),
      .wdata    (PWDATA),
      .xfer_o   (xfer_w[p]),
      .full_o   (full_w[p]),
      .count_o  (cnt_w[p]),
      .stamp_o  (stamp_w[p]),
      .event_o  (ev_w[p])
    );
  end

  // pin ownership: link first, then the narrowest enabled port
  always_comb begin
    logic taken;
    taken = 1'b0;
    po_d  = 32'h00000000;
    poe_d = 32'h00000000;
    for (int i = 0; i < `PCB_NPIN; i++) begin
      taken = link_en_q & LINK_PINS[i];
      for (int p = 0; p < `PCB_NPORT; p++) begin
        if (!taken && pcfg_q[p].enable && i < port_width(p)) begin
          taken = 1'b1;
          if (pcfg_q[p].dir_out) begin
            po_d[i]  = pcfg_q[p].open_drain ? 1'b0 : pout_w[p][i];
            poe_d[i] = pcfg_q[p].open_drain ? ~pout_w[p][i] : 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pin_o_q  <= 32'h00000000;
      pin_oe_q <= 32'h00000000;
      stb_q    <= 5'h00;
    end else begin
      pin_o_q  <= po_d;
      pin_oe_q <= poe_d;
      stb_q    <= stb_w;
    end
  end

  // status bits: only the bits already returned are cleared, so a new event survives
  assign stat_clr = (acc_rd && dec.rg == pcb_pkg::PCB_RG_GLB && dec.sub == `PCB_GLB_STAT)
                    ? prdata_q[4:0] : 5'h00;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      stat_q <= 5'h00;
      evt_q  <= 5'h00;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | ev_w;
      evt_q  <= ev_w;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  assign PRDATA     = prdata_q;
  assign PREADY     = pready_q;
  assign PSLVERR    = pslverr_q;
  assign PIN_O      = pin_o_q;
  assign PIN_OE     = pin_oe_q;
  assign STROBE_OUT = stb_q;
  assign PORT_EVENT = evt_q;
  assign IRQ        = irq_q;

endmodule : pcb_top

/* tb/pcb_monitor.sv */
// port-level checks on apb timing, errors, pin ownership and interrupt
`timescale 1ns/1ps
module pcb_monitor (
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RST,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // pins and interrupt
  input wire logic [31:0] PIN_OE,
  input wire logic        IRQ
);
  logic link_q;
  logic mask_q;

  default clocking mon_cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // mirrors of link enable and mask, from completed writes only
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) link_q <= 1'b0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'hA0) link_q <= PWDATA[0];
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) mask_q <= 1'b0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'hA8) mask_q <= |PWDATA[4:0];
  end

  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence bad_addr_s;
    setup_s ##0 (PADDR[1:0] != 2'h0 ||
                 PADDR inside {[8'h50:8'h7F], [8'h98:8'h9F], [8'hB0:8'hFF]});
  endsequence

  ready_after_setup_a: assert property (setup_s |=> PREADY)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
    else $error("pready without a setup");
  err_unmapped_a: assert property (bad_addr_s |=> PREADY && PSLVERR)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (setup_s ##0 PADDR == 8'h40 |=> !PSLVERR)
    else $error("error on mapped address");
  err_read_zero_a: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("unmapped read not zero");
  cb0_fixed_a: assert property (PREADY && !PWRITE && PADDR == 8'h80 |-> PRDATA == 32'h0)
    else $error("clock block 0 not fixed");
  link_pins_a: assert property (link_q [*3] |-> PIN_OE[15:8] == 8'h00)
    else $error("port drives link pins");
  irq_masked_a: assert property (!mask_q [*3] |-> !IRQ)
    else $error("interrupt while fully masked");
endmodule : pcb_monitor

/* tb/pcb_pins_model.sv */
// far side of the pins: input levels, ready strobes and a slow pin clock
`timescale 1ns/1ps
module pcb_pins_model (
  // clock
  input wire logic        clk,
  // pins
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe,
  output logic     [31:0] pin_i,
  // strobes
  output logic     [4:0]  rdy_in
);
  logic [31:0] ext_q;
  logic        clk_pin_q;

  initial begin
    ext_q     = 32'h0;
    clk_pin_q = 1'b0;
  end

  // driven pins read back their own level, released ones show this side
  assign pin_i  = (pin_o & pin_oe) | ({ext_q[31:1], clk_pin_q} & ~pin_oe);
  // strobe held asserted so qualified input is never stalled
  assign rdy_in = 5'h1F;

  task automatic set_ext(input logic [31:0] v);
    @(posedge clk);
    ext_q <= v;
  endtask : set_ext

  // four cycles a phase so the two-flop synchroniser sees each edge
  task automatic pulse(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk);
      clk_pin_q <= ~clk_pin_q;
      repeat (3) @(posedge clk);
    end
  endtask : pulse
endmodule : pcb_pins_model

/* tb/pcb_top_tb.sv */
// self-checking bench for pcb_top over apb with a pin model
`timescale 1ns/1ps
module pcb_top_tb;
  logic        MCLK;
  logic        RST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [31:0] PIN_I;
  logic [31:0] PIN_O;
  logic [31:0] PIN_OE;
  logic [4:0]  RDY_IN;
  logic [4:0]  STROBE_OUT;
  logic [4:0]  PORT_EVENT;
  logic        IRQ;
  int          num_errors;
  int          n_compared;
  int          k;
  logic [31:0] rd;
  logic [31:0] c0;

  pcb_top dut_u (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .RDY_IN(RDY_IN),
    .STROBE_OUT(STROBE_OUT), .PORT_EVENT(PORT_EVENT), .IRQ(IRQ));
  pcb_pins_model model_u (.clk(MCLK), .pin_o(PIN_O), .pin_oe(PIN_OE), .pin_i(PIN_I),
    .rdy_in(RDY_IN));

  always #5 MCLK = ~MCLK;

  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd      = PRDATA;
    c0[31]  = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
  endtask : apb

  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rdc

  task automatic wait_pin(input logic [31:0] oe, input logic [31:0] o);
    k = 0;
    while ((PIN_OE !== oe || PIN_O !== o) && k < 50) begin
      @(posedge MCLK);
      k++;
    end
    chk("pin enable", PIN_OE, oe);
    chk("pin value", PIN_O, o);
  endtask : wait_pin

  initial begin
    MCLK       = 1'b0;
    RST        = 1'b1;
    PSEL       = 1'b0;
    PENABLE    = 1'b0;
    PWRITE     = 1'b0;
    PADDR      = 8'h00;
    PWDATA     = 32'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    for (int p = 0; p < 5; p++) rdc("ctrl reset", 8'(p * 16), 32'h0);
    rdc("mask reset", 8'hA8, 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped", {c0[31], rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h80, 32'h0000FF01);
    rdc("block 0", 8'h80, 32'h0);
    rdc("block 1 reset", 8'h84, 32'h0);
    apb(1'b1, 8'h40, 32'h203);
    apb(1'b1, 8'h44, 32'hA5C30F96);
    k = 0;
    while (STROBE_OUT[4] !== 1'b1 && k < 50) begin
      @(posedge MCLK);
      k++;
    end
    chk("strobe out", {27'h0, STROBE_OUT}, 32'h10);
    wait_pin(32'hFFFFFFFF, 32'hA5C30F96);
    apb(1'b1, 8'h40, 32'h7);
    apb(1'b1, 8'h44, 32'h00FF5A3C);
    wait_pin(32'hFF00A5C3, 32'h0);
    apb(1'b1, 8'hA0, 32'h1);
    wait_pin(32'hFF0000C3, 32'h0);
    apb(1'b1, 8'hA0, 32'h0);
    // input word, event and interrupt
    model_u.set_ext(32'h3C5A96E2);
    apb(1'b1, 8'hA8, 32'h10);
    apb(1'b1, 8'h40, 32'h1);
    k = 0;
    while (PORT_EVENT[4] !== 1'b1 && k < 50) begin
      @(posedge MCLK);
      k++;
    end
    chk("event", {31'h0, PORT_EVENT[4]}, 32'h1);
    rdc("input word", 8'h44, 32'h3C5A96E2);
    chk("irq set", {31'h0, IRQ}, 32'h1);
    apb(1'b1, 8'h40, 32'h0);
    repeat (4) @(posedge MCLK);
    apb(1'b0, 8'hA4, 32'h0);
    chk("status", rd & 32'h1F, 32'h10);
    rdc("status clear", 8'hA4, 32'h0);
    repeat (2) @(posedge MCLK);
    chk("irq clear", {31'h0, IRQ}, 32'h0);
    // counter clocked from the pin, then divided by two
    apb(1'b1, 8'h84, 32'h1);
    apb(1'b1, 8'h40, 32'h9);
    apb(1'b0, 8'h48, 32'h0);
    c0 = rd;
    model_u.pulse(5);
    repeat (4) @(posedge MCLK);
    apb(1'b0, 8'h48, 32'h0);
    chk("pin count", {16'h0, rd[15:0]}, {16'h0, c0[15:0] + 16'h0005});
    c0 = rd;
    apb(1'b0, 8'h4C, 32'h0);
    chk("stamp", {16'h0, rd[15:0]}, {16'h0, c0[15:0] - 16'h0001});
    apb(1'b1, 8'h84, 32'h101);
    model_u.pulse(6);
    repeat (4) @(posedge MCLK);
    apb(1'b0, 8'h48, 32'h0);
    chk("divided count", {16'h0, rd[15:0]}, {16'h0, c0[15:0] + 16'h0003});
    print_verdict();
  end
endmodule : pcb_top_tb

bind pcb_top pcb_monitor mon_u (
  .MCLK(MCLK),
  .RST(RST),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .PIN_OE(PIN_OE),
  .IRQ(IRQ)
);
